// ==== design/adsp_pkg.sv ====
// package of the serial data and configuration port of a 16-bit converter
// assumes a 200 MHz core clock and a host that acts as serial master
package adsp_pkg;

  // ****************************************
  // word sizes and frame lengths
  // ****************************************
  localparam int WORD_BITS = 16;
  localparam int FRAME_LONG_BITS = 32;
  localparam int CNT_BITS = 6;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [15:0] CONFIG_RESET = 16'h058b;

  // ****************************************
  // configuration word field positions
  // ****************************************
  localparam int POS_START = 15;
  localparam int POS_INPUT_SEL = 12;
  localparam int POS_GAIN = 9;
  localparam int POS_MODE = 8;
  localparam int POS_KEY = 1;
  localparam int POS_RSVD = 0;
  localparam logic [1:0] WRITE_KEY_VALID = 2'h1;
  localparam logic MODE_CONTINUOUS = 1'h0;
  localparam logic MODE_SINGLE = 1'h1;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_PS = 5000;
  localparam longint TIMEOUT_MS = 28;
  localparam longint TIMEOUT_CYCLES = (TIMEOUT_MS * 64'd1000000000) / CLK_PERIOD_PS;
  localparam int READY_LEAD_NS = 8;
  localparam int TIMEOUT_CNT_BITS = 23;

  // configuration word, most significant field first
  typedef struct packed {
    logic start;
    logic [2:0] input_selector;
    logic [2:0] gain_range;
    logic mode;
    logic [2:0] rate;
    logic temp_mode;
    logic pull_up;
    logic [1:0] write_key;
    logic rsvd;
  } adsp_cfg_t;

  // one finished conversion handed over by the converter
  typedef struct packed {
    logic done;
    logic [15:0] data;
  } adsp_result_t;

endpackage

// ==== design/adsp_port.sv ====
// serial port, result buffer and configuration word of the converter
// assumes the converter signals done / near-done as core-clock pulses;
// chip select, serial clock and data in are asynchronous pins
`timescale 1ns/1ps
`default_nettype none

// How it works
// - every frame both returns the result and takes configuration, no command
// - continuous mode starts a new conversion whenever none is running
// - single mode converts once per start bit written as one
// - result buffer only changes when a newer conversion finishes
// - data out held low while an unread result waits
// - result leaves msb first, bit 15 on first rising serial edge
// - serial input sampled on falling serial edges
// - long frame sends result then configuration readback, msb first
// - readback in long frame shows the word written earlier in it
// - frame begins with the buffered result on first rising edge
// - no new result: line high, same result returned again
// - result reads zero after reset until first conversion ends
// - result is a read-only sixteen-bit two's complement word
// - configuration word resets to 058b
// - start bit begins conversion only in single mode when idle, reads zero
// - bits 14:12 select the input pair, default 000
// - bits 11:9 select full-scale range, default 010
// - bit 8 selects continuous or single mode, single after reset
// - write only when write key field equals 01
// - serial clock held low long resets the serial interface
// - chip select high resets interface and releases data out
// - unread result in continuous mode: line returns high shortly before next result
module adsp_port #(
  parameter longint TIMEOUT_LEN = adsp_pkg::TIMEOUT_CYCLES
) (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_chip_select_n,
  input wire logic i_sclk,
  input wire logic i_din,
  input wire adsp_pkg::adsp_result_t i_result,
  input wire logic i_result_soon,
  output logic o_data_out_ready_n,
  output logic o_data_out_ready_n_oe,
  output logic o_conv_start,
  output logic [2:0] o_input_selector,
  output logic [2:0] o_gain_range,
  output logic o_single_mode
);
  import adsp_pkg::*;

  initial begin
    if (TIMEOUT_LEN < 1 || TIMEOUT_LEN >= (64'd1 << TIMEOUT_CNT_BITS)) begin
      $error("TIMEOUT_LEN out of range");
    end
  end

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [1:0] cs_sync_reg;
  logic [1:0] sclk_sync_reg;
  logic [1:0] din_sync_reg;
  logic sclk_last_reg;

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cs_sync_reg <= 2'h3;
      sclk_sync_reg <= 2'h0;
      din_sync_reg <= 2'h0;
      sclk_last_reg <= 1'b0;
    end else begin
      cs_sync_reg <= {cs_sync_reg[0], i_chip_select_n};
      sclk_sync_reg <= {sclk_sync_reg[0], i_sclk};
      din_sync_reg <= {din_sync_reg[0], i_din};
      sclk_last_reg <= sclk_sync_reg[1];
    end
  end

  wire cs_high = cs_sync_reg[1];
  wire sclk_now = sclk_sync_reg[1];
  wire din_now = din_sync_reg[1];

  // ****************************************
  // frame state
  // ****************************************
  adsp_cfg_t cfg_reg;
  logic [15:0] result_reg;
  logic [15:0] tx_reg;
  logic [15:0] rx_reg;
  logic [CNT_BITS-1:0] rise_cnt_reg;
  logic [CNT_BITS-1:0] fall_cnt_reg;
  logic [TIMEOUT_CNT_BITS-1:0] idle_cnt_reg;
  logic new_data_reg;
  logic busy_reg;
  logic dout_reg;
  logic oe_reg;
  logic start_reg;

  wire active = !cs_high;
  wire sclk_rise = active && sclk_now && !sclk_last_reg;
  wire sclk_fall = active && !sclk_now && sclk_last_reg;
  wire timed_out = active && !sclk_now &&
                   (idle_cnt_reg == TIMEOUT_CNT_BITS'(TIMEOUT_LEN - 1));
  wire link_reset = cs_high || timed_out;

  wire [15:0] rx_full = {rx_reg[14:0], din_now};
  wire commit_edge = sclk_fall && (fall_cnt_reg == CNT_BITS'(WORD_BITS - 1));
  wire key_ok = rx_full[POS_KEY +: 2] == WRITE_KEY_VALID;
  wire cfg_write = commit_edge && key_ok;

  // start bit reads zero, reserved bit one
  wire [15:0] cfg_rd = {1'b0, cfg_reg[14:1], 1'b1};

  wire at_first_bit = rise_cnt_reg == '0;
  wire in_result = rise_cnt_reg < CNT_BITS'(WORD_BITS);
  wire at_readback = rise_cnt_reg == CNT_BITS'(WORD_BITS);
  wire past_frame = rise_cnt_reg >= CNT_BITS'(FRAME_LONG_BITS);
  wire frame_done = fall_cnt_reg >= CNT_BITS'(FRAME_LONG_BITS);

  // a constant input line yields key 00 or 11 and so never writes
  wire single_req = cfg_write && rx_full[POS_START] && rx_full[POS_MODE] && !busy_reg;
  wire cont_req = (cfg_reg.mode == MODE_CONTINUOUS) && !busy_reg && !start_reg;

  // ****************************************
  // serial counters
  // ****************************************
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rise_cnt_reg <= '0;
      fall_cnt_reg <= '0;
      idle_cnt_reg <= '0;
    end else if (link_reset) begin
      rise_cnt_reg <= '0;
      fall_cnt_reg <= '0;
      idle_cnt_reg <= '0;
    end else begin
      if (sclk_rise && !past_frame) begin
        rise_cnt_reg <= rise_cnt_reg + CNT_BITS'(1);
      end
      if (sclk_fall && !frame_done) begin
        fall_cnt_reg <= fall_cnt_reg + CNT_BITS'(1);
      end
      idle_cnt_reg <= sclk_now ? '0 : idle_cnt_reg + TIMEOUT_CNT_BITS'(1);
    end
  end

  // ****************************************
  // receive side
  // ****************************************
  // capture on falling edge
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rx_reg <= '0;
    end else if (sclk_fall) begin
      rx_reg <= rx_full;
    end
  end

  // reset value; fields stored as written, start stored as zero, reserved as one
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cfg_reg <= adsp_cfg_t'(CONFIG_RESET);
    end else if (cfg_write) begin
      // configuration taken inside the data frame
      cfg_reg <= adsp_cfg_t'({1'b0, rx_full[14:1], 1'b1});
    end
  end

  // ****************************************
  // conversion control and result buffer
  // ****************************************
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      start_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      // continuous restart; single-shot once; only when idle
      start_reg <= cont_req || single_req;
      if (start_reg) begin
        busy_reg <= 1'b1;
      end else if (i_result.done) begin
        busy_reg <= 1'b0;
      end
    end
  end

  // zero until first result; only overwritten by newer
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      result_reg <= RESULT_RESET;
    end else if (i_result.done) begin
      result_reg <= i_result.data;
    end
  end

  // a result arriving as a frame starts stays flagged: set wins over clear
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      new_data_reg <= 1'b0;
    end else if (i_result.done) begin
      new_data_reg <= 1'b1;
    end else if (sclk_rise && at_first_bit) begin
      new_data_reg <= 1'b0;
    end else if (i_result_soon && cfg_reg.mode == MODE_CONTINUOUS) begin
      // unread result withdrawn before the next one lands
      new_data_reg <= 1'b0;
    end
  end

  // ****************************************
  // transmit side
  // ****************************************
  // the result is copied into tx_reg at the first bit, so a result that
  // arrives mid-frame cannot tear the word being shifted out
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tx_reg <= '0;
      dout_reg <= 1'b1;
      oe_reg <= 1'b0;
    end else if (cs_high) begin
      dout_reg <= 1'b1;
      oe_reg <= 1'b0;
    end else begin
      oe_reg <= 1'b1;
      if (sclk_rise) begin
        if (at_first_bit) begin
          // bit 15 of the buffered result first
          dout_reg <= result_reg[15];
          tx_reg <= {result_reg[14:0], 1'b0};
        end else if (at_readback) begin
          dout_reg <= cfg_rd[15];
          tx_reg <= {cfg_rd[14:0], 1'b0};
        end else if (in_result || !past_frame) begin
          dout_reg <= tx_reg[15];
          tx_reg <= {tx_reg[14:0], 1'b0};
        end else begin
          dout_reg <= 1'b0;
        end
      end else if (at_first_bit || frame_done) begin
        dout_reg <= !new_data_reg;
      end
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign o_data_out_ready_n = dout_reg;
  assign o_data_out_ready_n_oe = oe_reg;
  assign o_conv_start = start_reg;
  assign o_input_selector = cfg_reg.input_selector;
  assign o_gain_range = cfg_reg.gain_range;
  assign o_single_mode = cfg_reg.mode;

endmodule

`default_nettype wire

// ==== bench/adsp_port_assertions.sv ====
// checker for the serial port, sees the top module's ports only
// assumes one core clock domain and the asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// port checker
// ****************************************
module adsp_port_assertions #(
  parameter longint TIMEOUT_LEN = adsp_pkg::TIMEOUT_CYCLES
) (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_chip_select_n,
  input wire logic i_sclk,
  input wire logic i_din,
  input wire adsp_pkg::adsp_result_t i_result,
  input wire logic i_result_soon,
  input wire logic o_data_out_ready_n,
  input wire logic o_data_out_ready_n_oe,
  input wire logic o_conv_start,
  input wire logic [2:0] o_input_selector,
  input wire logic [2:0] o_gain_range,
  input wire logic o_single_mode
);
  import adsp_pkg::*;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  oe_rise_a: assert property ($fell(i_chip_select_n) ##1 !i_chip_select_n[*4]
    |-> o_data_out_ready_n_oe) else $error("data out not driven after select");
  oe_drop_a: assert property ($rose(i_chip_select_n)
    |-> ##[2:5] !o_data_out_ready_n_oe) else $error("data out still driven");
  released_high_a: assert property (!o_data_out_ready_n_oe |-> o_data_out_ready_n)
    else $error("released data out not high");
  oe_cause_a: assert property ($rose(o_data_out_ready_n_oe) |-> !$past(i_chip_select_n, 2))
    else $error("data out driven without select");
  reset_cfg_a: assert property ($rose(i_rst_b) |-> o_input_selector == 3'h0
    && o_gain_range == 3'h2 && o_single_mode) else $error("bad config after reset");
  start_gap_a: assert property (o_conv_start |=> !o_conv_start[*3])
    else $error("start repeated during conversion");
  cfg_frame_a: assert property (!$stable({o_input_selector, o_gain_range, o_single_mode})
    |-> o_data_out_ready_n_oe) else $error("config changed outside frame");
  single_start_a: assert property (o_conv_start && o_single_mode
    |-> $past(o_data_out_ready_n_oe, 2)) else $error("single start without frame");
  cover property (o_conv_start && o_single_mode);
  cover property (o_conv_start && !o_single_mode);
  cover property (o_data_out_ready_n_oe && !o_data_out_ready_n && !i_sclk);
endmodule
bind adsp_port adsp_port_assertions #(.TIMEOUT_LEN(TIMEOUT_LEN)) adsp_port_assertions_i (
  .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_chip_select_n(i_chip_select_n),
  .i_sclk(i_sclk), .i_din(i_din), .i_result(i_result), .i_result_soon(i_result_soon),
  .o_data_out_ready_n(o_data_out_ready_n), .o_data_out_ready_n_oe(o_data_out_ready_n_oe),
  .o_conv_start(o_conv_start), .o_input_selector(o_input_selector),
  .o_gain_range(o_gain_range), .o_single_mode(o_single_mode));
`default_nettype wire

// ==== bench/adsp_host_model.sv ====
// host model acting as serial master with a 64 ns serial clock
// assumes the data out pin level already includes the pull-up
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// serial master
// ****************************************
module adsp_host_model (
  output logic o_chip_select_n,
  output logic o_sclk,
  output logic o_din,
  input wire logic i_data_out_ready_n
);
  initial begin
    o_chip_select_n = 1'b1;
    o_sclk = 1'b0;
    o_din = 1'b0;
  end
  // frame cut short: select stays low, serial clock left low past the timeout
  task automatic cut(input int n);
    o_chip_select_n = 1'b0;
    o_din = 1'b1;
    #100;
    for (int k = 0; k < n; k++) begin
      #16 o_sclk = 1'b1;
      #32 o_sclk = 1'b0;
      #16;
    end
    #1500;
  endtask
  task automatic frame(input int n, input logic [15:0] w, output logic rdy,
                       output logic [31:0] rx);
    rx = 32'h0;
    o_chip_select_n = 1'b0;
    #100 rdy = i_data_out_ready_n;
    for (int k = 0; k < n; k++) begin
      // din settled long before the fall, constant in the tail
      o_din = (k < 16) ? w[15 - k] : 1'b0;
      #16 o_sclk = 1'b1;
      #32 rx = {rx[30:0], i_data_out_ready_n};
      o_sclk = 1'b0;
      #16;
    end
    #100 o_chip_select_n = 1'b1;
    #100;
  endtask
endmodule
`default_nettype wire

// ==== bench/adsp_port_tb.sv ====
// self-checking bench of the serial port; the bench plays the converter
// assumes a weak pull-up on the data out pin while it is released
`timescale 1ns/1ps
`default_nettype none
module adsp_port_tb;
  import adsp_pkg::*;
  logic clk, rst_b, soon, dout, oe, start, single;
  wire logic cs_n, sclk, din;
  logic [2:0] sel, gain;
  adsp_result_t res;
  int miscompares = 0, n_compared = 0, n_start = 0, cyc = 0;
  wire logic pin = oe ? dout : 1'b1;
  adsp_port #(.TIMEOUT_LEN(200)) adsp_port_i (.i_core_clk(clk), .i_rst_b(rst_b),
    .i_chip_select_n(cs_n), .i_sclk(sclk), .i_din(din), .i_result(res),
    .i_result_soon(soon), .o_data_out_ready_n(dout), .o_data_out_ready_n_oe(oe),
    .o_conv_start(start), .o_input_selector(sel), .o_gain_range(gain),
    .o_single_mode(single));
  adsp_host_model adsp_host_model_i (.o_chip_select_n(cs_n), .o_sclk(sclk), .o_din(din),
    .i_data_out_ready_n(pin));
  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic conv_done(logic [15:0] d);
    @(negedge clk) res = {1'b1, d};
    @(negedge clk) res.done = 1'b0;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    logic r;
    logic [31:0] rx;
    chk("sel", 32'(sel), 32'h0);
    chk("gain", 32'(gain), 32'h2);
    chk("single", 32'(single), 32'h1);
    adsp_host_model_i.frame(32, 16'h0, r, rx);
    chk("idle", {r, rx[30:0]}, 32'h8000058b);
    $display("reset test over");
  endtask
  task automatic t_single;
    logic r;
    logic [31:0] rx;
    int s;
    s = n_start;
    adsp_host_model_i.frame(16, 16'hd98b, r, rx);
    chk("starts", n_start, s + 1);
    chk("sel", 32'(sel), 32'h5);
    chk("gain", 32'(gain), 32'h4);
    conv_done(16'h8001);
    adsp_host_model_i.frame(16, 16'h0, r, rx);
    chk("fresh", {r, rx[30:0]}, 32'h00008001);
    adsp_host_model_i.frame(16, 16'h0, r, rx);
    chk("stale", {r, rx[30:0]}, 32'h80008001);
    chk("starts", n_start, s + 1);
    $display("single test over");
  endtask
  task automatic t_cont;
    logic r;
    logic [31:0] rx;
    int s;
    adsp_host_model_i.frame(32, 16'h048b, r, rx);
    chk("readback", rx, 32'h8001048b);
    chk("single", 32'(single), 32'h0);
    s = n_start;
    conv_done(16'h1234);
    repeat (4) @(negedge clk);
    chk("restart", n_start, s + 1);
    @(negedge clk) soon = 1'b1;
    @(negedge clk) soon = 1'b0;
    adsp_host_model_i.frame(16, 16'h0, r, rx);
    chk("lead", {r, rx[30:0]}, 32'h80001234);
    $display("continuous test over");
  endtask
  task automatic t_key;
    logic r;
    logic [31:0] rx;
    adsp_host_model_i.frame(32, 16'h728d, r, rx);
    chk("nop", rx, 32'h1234048b);
    chk("gain", 32'(gain), 32'h2);
    $display("key test over");
  endtask
  task automatic t_timeout;
    logic r;
    logic [31:0] rx;
    adsp_host_model_i.cut(8);
    adsp_host_model_i.frame(16, 16'h0, r, rx);
    chk("timeout", {r, rx[30:0]}, 32'h80001234);
    $display("timeout test over");
  endtask
  task automatic t_rerun;
    logic r;
    logic [31:0] rx;
    int s;
    @(negedge clk) rst_b = 1'b0;
    repeat (8) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    s = n_start;
    chk("sel", 32'(sel), 32'h0);
    chk("single", 32'(single), 32'h1);
    adsp_host_model_i.frame(32, 16'h0, r, rx);
    chk("rerun", {r, rx[30:0]}, 32'h8000058b);
    chk("starts", n_start, s);
    $display("second reset test over");
  endtask
  // ****************************************
  // clock, reset, sequence
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (start === 1'b1) n_start++;
    if (cyc == 20000) begin
      miscompares++;
      close_out;
    end
  end
  initial begin
    rst_b = 1'b0;
    soon = 1'b0;
    res = '0;
    repeat (8) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    t_reset;
    t_single;
    t_cont;
    t_key;
    t_timeout;
    t_rerun;
    close_out;
  end
endmodule
`default_nettype wire
